// ---- scr_slot_cap.sv ----
// Slot capability register bank with AHB-Lite slave, strap capture and power limit message
//
// Behaviour
// - Bits 31:19 show the slot number software wrote into slot information.
// - Bit 18 shows interlock presence taken from the general control register.
// - Bit 17 always reads zero: command completion notification is supported.
// - Scale bits 16:15 encode 1.0, 0.1, 0.01 or 0.001 times the value.
// - Scale and value accept one write per reset; that write sends a limit message.
// - Scale and value clear on reset, then load from EEPROM when present.
// - Eight-bit value bits 14:7 times scale gives the slot's maximum watts.
// - Bit 6 shows hot-plug capable, mirroring general control bit 14.
// - Hot-plug capable clears on reset, then takes a default decoded from downstream port straps.
// - Bit 5 shows surprise removal allowed, mirroring general control bit 13.
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module scr_slot_cap
    import scr_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic [31:0]                      hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire logic [SCR_STRAP_W-1:0]      downstreamPortStraps,
    input  wire scr_pkg::scr_limit_load_type eepromLoad,
    output scr_pkg::scr_limit_load_type      powerLimitMsg,
    output logic                             hotplugCapable,
    output logic                             surpriseRemovalOk
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]               hrdata_reg;
    logic [31:0]               hrdata_next;
    logic                      hreadyout_reg;
    logic                      hresp_reg;
    logic                      wrPending_reg;
    logic [SCR_ADDR_W-1:0]     wrAddr_reg;
    logic                      strapDone_reg;
    logic                      genInterlock_reg;
    logic                      genHotplugCap_reg;
    logic                      genSurprise_reg;
    logic [SCR_SLOT_NUM_W-1:0] slotNumber_reg;
    logic                      hotplugCapable_reg;
    logic                      surpriseRemovalOk_reg;
    logic                      addrPhase;
    logic                      wrGenCtrl;
    logic                      wrSlotInfo;
    logic                      wrCapWord;
    logic                      strapHotplug;
    logic [31:0]               capWord;
    scr_limit_load_type        swLimitWrite;
    scr_power_limit_type       powerLimit;
    scr_limit_load_type        limitMsg;
    logic                      limitWriteUsed;

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase; only word transfers are expected, hsize is not checked
    assign addrPhase = hsel && htrans[1] && hready;

    // A write lands one cycle after its address phase, when hwdata stands
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPending_reg <= 1'b0;
        end
        else
        begin
            wrPending_reg <= addrPhase && hwrite;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrAddr_reg <= '0;
        end
        else if (addrPhase && hwrite)
        begin
            wrAddr_reg <= haddr[SCR_ADDR_W-1:0];
        end
    end

    // Zero wait states and always OKAY: every register is a plain flop
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hreadyout_reg <= 1'b1;
        end
        else
        begin
            hreadyout_reg <= 1'b1;
        end
    end

    // Never an error response; flopped so every bus output leaves a register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hresp_reg <= 1'b0;
        end
        else
        begin
            hresp_reg <= 1'b0;
        end
    end

    assign wrGenCtrl  = wrPending_reg && (wrAddr_reg == SCR_GEN_CTRL_ADDR);
    assign wrSlotInfo = wrPending_reg && (wrAddr_reg == SCR_SLOT_INFO_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // Straps are sampled on the first edge after reset release, never under reset
    assign strapHotplug = downstreamPortStraps[SCR_STRAP_HP_BIT_A]
                        | downstreamPortStraps[SCR_STRAP_HP_BIT_B];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strapDone_reg <= 1'b0;
        end
        else
        begin
            strapDone_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // General control bits feeding the capability word
    // Strap default lands on the first edge after release, keeping the reset branch constant
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            genHotplugCap_reg <= 1'b0;
        end
        else if (wrGenCtrl)
        begin
            genHotplugCap_reg <= hwdata[SCR_GC_HP_CAP_BIT];
        end
        else if (!strapDone_reg)
        begin
            genHotplugCap_reg <= strapHotplug;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            genSurprise_reg <= SCR_SURPRISE_RESET;
        end
        else if (wrGenCtrl)
        begin
            genSurprise_reg <= hwdata[SCR_GC_SURPRISE_BIT];
        end
    end

    // Interlock presence has no strap and starts absent
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            genInterlock_reg <= SCR_INTERLOCK_RESET;
        end
        else if (wrGenCtrl)
        begin
            genInterlock_reg <= hwdata[SCR_GC_INTERLOCK_BIT];
        end
    end

    // Slot information: software owns uniqueness of the number across slots
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slotNumber_reg <= '0;
        end
        else if (wrSlotInfo)
        begin
            slotNumber_reg <= hwdata[SCR_SI_SLOT_NUM_LSB +: SCR_SLOT_NUM_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write-once power limit; any write to the capability word spends the chance
    // Later writes still reach the holder, which drops them without a message
    assign wrCapWord = wrPending_reg && (wrAddr_reg == SCR_SLOT_CAP_ADDR);

    // Single driver for the whole carrier
    assign swLimitWrite = '{
        valid: wrCapWord,
        limit: '{scale: scr_scale_type'(hwdata[SCR_SCALE_LSB +: SCR_SCALE_W]),
                 value: hwdata[SCR_VALUE_LSB +: SCR_VALUE_W]}
    };

    scr_power_limit u_power_limit
    (
        .clk        (clk),
        .rst_b      (rst_b),
        .eepromLoad (eepromLoad),
        .swWrite    (swLimitWrite),
        .limit      (powerLimit),
        .limitMsg   (limitMsg),
        .writeUsed  (limitWriteUsed)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Capability word assembly
    always_comb
    begin
        capWord                                       = SCR_ZERO_WORD;
        capWord[SCR_SLOT_NUM_LSB +: SCR_SLOT_NUM_W]   = slotNumber_reg;
        capWord[SCR_INTERLOCK_BIT]                    = genInterlock_reg;
        capWord[SCR_NO_CMD_BIT]                       = SCR_NO_CMD_VALUE;
        capWord[SCR_SCALE_LSB +: SCR_SCALE_W]         = powerLimit.scale;
        capWord[SCR_VALUE_LSB +: SCR_VALUE_W]         = powerLimit.value;
        capWord[SCR_HP_CAP_BIT]                       = genHotplugCap_reg;
        capWord[SCR_SURPRISE_BIT]                     = genSurprise_reg;
    end

    // Read data is registered in the address phase so it stands in the data phase
    always_comb
    begin
        hrdata_next = SCR_ZERO_WORD;
        case (haddr[SCR_ADDR_W-1:0])
            SCR_SLOT_CAP_ADDR:
            begin
                hrdata_next = capWord;
            end
            SCR_GEN_CTRL_ADDR:
            begin
                hrdata_next[SCR_GC_INTERLOCK_BIT] = genInterlock_reg;
                hrdata_next[SCR_GC_HP_CAP_BIT]    = genHotplugCap_reg;
                hrdata_next[SCR_GC_SURPRISE_BIT]  = genSurprise_reg;
            end
            SCR_SLOT_INFO_ADDR:
            begin
                hrdata_next[SCR_SI_SLOT_NUM_LSB +: SCR_SLOT_NUM_W] = slotNumber_reg;
            end
            default:
            begin
                hrdata_next = SCR_ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hrdata_reg <= SCR_ZERO_WORD;
        end
        else if (addrPhase && !hwrite)
        begin
            hrdata_reg <= hrdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status outputs, registered so they lag the source flops by one cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hotplugCapable_reg <= 1'b0;
        end
        else
        begin
            hotplugCapable_reg <= genHotplugCap_reg;
        end
    end

    // Surprise output comes up set, so it agrees with the capability word at reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            surpriseRemovalOk_reg <= SCR_SURPRISE_RESET;
        end
        else
        begin
            surpriseRemovalOk_reg <= genSurprise_reg;
        end
    end

    assign hrdata            = hrdata_reg;
    assign hreadyout         = hreadyout_reg;
    assign hresp             = hresp_reg;
    assign powerLimitMsg     = limitMsg;
    assign hotplugCapable    = hotplugCapable_reg;
    assign surpriseRemovalOk = surpriseRemovalOk_reg;

endmodule

// ---- scr_pkg.sv ----
// Package with register map, field layout and carrier types of the slot capability block
package scr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [11:0] SCR_SLOT_CAP_ADDR  = 12'h00A4;
    localparam logic [11:0] SCR_GEN_CTRL_ADDR  = 12'h00B4;
    localparam logic [11:0] SCR_SLOT_INFO_ADDR = 12'h00B8;
    localparam int          SCR_ADDR_W         = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // Slot capability field positions
    localparam int SCR_SLOT_NUM_LSB  = 19;
    localparam int SCR_SLOT_NUM_W    = 13;
    localparam int SCR_INTERLOCK_BIT = 18;
    localparam int SCR_NO_CMD_BIT    = 17;
    localparam int SCR_SCALE_LSB     = 15;
    localparam int SCR_SCALE_W       = 2;
    localparam int SCR_VALUE_LSB     = 7;
    localparam int SCR_VALUE_W       = 8;
    localparam int SCR_HP_CAP_BIT    = 6;
    localparam int SCR_SURPRISE_BIT  = 5;

    // General control field positions
    localparam int SCR_GC_INTERLOCK_BIT = 15;
    localparam int SCR_GC_HP_CAP_BIT    = 14;
    localparam int SCR_GC_SURPRISE_BIT  = 13;

    // Slot information field position
    localparam int SCR_SI_SLOT_NUM_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and constants
    localparam logic       SCR_NO_CMD_VALUE     = 1'b0;
    localparam logic       SCR_SURPRISE_RESET   = 1'b1;
    localparam logic       SCR_INTERLOCK_RESET  = 1'b0;
    localparam logic [31:0] SCR_ZERO_WORD       = 32'h0000_0000;
    localparam int         SCR_STRAP_W          = 3;
    localparam int         SCR_STRAP_HP_BIT_A   = 0;
    localparam int         SCR_STRAP_HP_BIT_B   = 2;

    // Power limit scale encodings
    typedef enum logic [1:0] {
        SCR_SCALE_1     = 2'b00,
        SCR_SCALE_0P1   = 2'b01,
        SCR_SCALE_0P01  = 2'b10,
        SCR_SCALE_0P001 = 2'b11
    } scr_scale_type;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        scr_scale_type          scale;
        logic [SCR_VALUE_W-1:0] value;
    } scr_power_limit_type;

    typedef struct packed {
        logic                valid;
        scr_power_limit_type limit;
    } scr_limit_load_type;

    localparam scr_power_limit_type SCR_LIMIT_RESET = '{scale: SCR_SCALE_1, value: 8'h00};

endpackage

// ---- scr_power_limit.sv ----
// Write-once power limit holder with EEPROM load and limit message launch
`timescale 1ns/10ps
module scr_power_limit
    import scr_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire scr_pkg::scr_limit_load_type eepromLoad,
    input  wire scr_pkg::scr_limit_load_type swWrite,
    output scr_pkg::scr_power_limit_type     limit,
    output scr_pkg::scr_limit_load_type      limitMsg,
    output logic                             writeUsed
);

    scr_power_limit_type limit_reg;
    logic                writeUsed_reg;
    scr_limit_load_type  limitMsg_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Field storage: cleared by reset, then EEPROM, then one software write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            limit_reg <= SCR_LIMIT_RESET;
        end
        else if (swWrite.valid && !writeUsed_reg)
        begin
            limit_reg <= swWrite.limit;
        end
        else if (eepromLoad.valid)
        begin
            limit_reg <= eepromLoad.limit;
        end
    end

    // Only reset reopens the field; later writes are silently dropped
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            writeUsed_reg <= 1'b0;
        end
        else if (swWrite.valid)
        begin
            writeUsed_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle message request carrying the newly accepted limit
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            limitMsg_reg <= '{valid: 1'b0, limit: SCR_LIMIT_RESET};
        end
        else
        begin
            limitMsg_reg.valid <= swWrite.valid && !writeUsed_reg;
            if (swWrite.valid && !writeUsed_reg)
            begin
                limitMsg_reg.limit <= swWrite.limit;
            end
        end
    end

    assign limit     = limit_reg;
    assign limitMsg  = limitMsg_reg;
    assign writeUsed = writeUsed_reg;

endmodule

// ---- scr_slot_cap_asserts.sv ----
// Concurrent assertions watching the slot capability block ports
`timescale 1ns/10ps
module scr_slot_cap_asserts
    import scr_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst_b,
    input wire logic                        hsel,
    input wire logic [31:0]                 haddr,
    input wire logic [1:0]                  htrans,
    input wire logic                        hwrite,
    input wire logic [2:0]                  hsize,
    input wire logic [31:0]                 hwdata,
    input wire logic                        hready,
    input wire logic [31:0]                 hrdata,
    input wire logic                        hreadyout,
    input wire logic                        hresp,
    input wire logic [SCR_STRAP_W-1:0]      downstreamPortStraps,
    input wire scr_pkg::scr_limit_load_type eepromLoad,
    input wire scr_pkg::scr_limit_load_type powerLimitMsg,
    input wire logic                        hotplugCapable,
    input wire logic                        surpriseRemovalOk
);
    logic        wrPendReg;
    logic [11:0] wrAddrReg;
    logic [13:0] slotIlReg;
    logic [9:0]  limitReg;
    logic        usedReg;
    logic        msgSeenReg;
    logic [1:0]  rstAgeReg;

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of what software and EEPROM stored; software write wins a tie
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPendReg <= 1'b0;
            wrAddrReg <= 12'h000;
            slotIlReg <= 14'h0000;
            limitReg <= 10'h000;
            usedReg <= 1'b0;
            msgSeenReg <= 1'b0;
            rstAgeReg <= 2'h0;
        end
        else
        begin
            wrPendReg <= hsel && htrans[1] && hready && hwrite;
            wrAddrReg <= haddr[11:0];
            msgSeenReg <= msgSeenReg || powerLimitMsg.valid;
            // Edges since reset release, saturating; the strap default shows after the second
            if (rstAgeReg != 2'h3)
                rstAgeReg <= rstAgeReg + 2'h1;
            if (wrPendReg && wrAddrReg == SCR_SLOT_INFO_ADDR)
                slotIlReg[13:1] <= hwdata[12:0];
            if (wrPendReg && wrAddrReg == SCR_GEN_CTRL_ADDR)
                slotIlReg[0] <= hwdata[15];
            if (eepromLoad.valid)
                limitReg <= eepromLoad.limit;
            if (wrPendReg && wrAddrReg == SCR_SLOT_CAP_ADDR && !usedReg)
                limitReg <= hwdata[16:7];
            if (wrPendReg && wrAddrReg == SCR_SLOT_CAP_ADDR)
                usedReg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence sAddr(logic w, logic [11:0] a);
        hsel && htrans[1] && hready && hwrite == w && haddr[11:0] == a;
    endsequence

    property pFollow(logic o, logic d);
        sAddr(1'b1, SCR_GEN_CTRL_ADDR) ##1 1'b1 |-> ##2 o == $past(d, 2);
    endproperty

    AST_BUS_OKAY: assert property (hresp == 1'b0 && hreadyout)
        else $error("bus answer not ready or not okay");
    AST_SLOT_FIELDS: assert property (sAddr(1'b0, SCR_SLOT_CAP_ADDR) |=>
        hrdata[31:18] == $past(slotIlReg)) else $error("slot number or interlock wrong");
    AST_NO_CMD: assert property (sAddr(1'b0, SCR_SLOT_CAP_ADDR) |=>
        !hrdata[17] && hrdata[4:0] == 5'h00) else $error("hardwired bits not zero");
    AST_LIMIT_READ: assert property (sAddr(1'b0, SCR_SLOT_CAP_ADDR) |=>
        hrdata[16:7] == $past(limitReg)) else $error("power limit readback wrong");
    AST_FIRST_WRITE: assert property (wrPendReg && wrAddrReg == SCR_SLOT_CAP_ADDR
        && !usedReg |=> powerLimitMsg.valid) else $error("first limit write sent no message");
    AST_MSG_CAUSE: assert property (powerLimitMsg.valid |->
        $past(wrPendReg && wrAddrReg == SCR_SLOT_CAP_ADDR)) else $error("message without write");
    AST_MSG_ONCE: assert property (powerLimitMsg.valid |-> !msgSeenReg)
        else $error("second limit message since reset");
    AST_MSG_PULSE: assert property (powerLimitMsg.valid |=> !powerLimitMsg.valid)
        else $error("limit message longer than one cycle");
    AST_MSG_LIMIT: assert property (powerLimitMsg.valid |->
        powerLimitMsg.limit == $past(hwdata[16:7])) else $error("message limit wrong");
    AST_HP_FOLLOW: assert property (pFollow(hotplugCapable, hwdata[14]))
        else $error("hot-plug output does not follow control");
    AST_SURPRISE_FOLLOW: assert property (pFollow(surpriseRemovalOk, hwdata[13]))
        else $error("surprise output does not follow control");
    AST_HP_STRAP: assert property (rstAgeReg == 2'h2 |-> hotplugCapable ==
        $past(downstreamPortStraps[SCR_STRAP_HP_BIT_A] | downstreamPortStraps[SCR_STRAP_HP_BIT_B], 2))
        else $error("hot-plug default does not follow straps");
endmodule

bind scr_slot_cap scr_slot_cap_asserts chk_u (
    .clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .downstreamPortStraps, .eepromLoad,
    .powerLimitMsg, .hotplugCapable, .surpriseRemovalOk
);

// ---- tb.sv ----
// Self-checking testbench for the slot capability block
`timescale 1ns/10ps
module tb;
    import scr_pkg::*;
    logic               clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic               hotplugCapable, surpriseRemovalOk, mIl, mHp, mSur, mUsed;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [1:0]         htrans;
    logic [2:0]         straps;
    logic [12:0]        mSlot;
    logic [9:0]         mLim;
    logic [9:0]         msgQ[$];
    scr_limit_load_type eepromLoad, powerLimitMsg;
    int                 nErrors, samplesChecked;
    integer             seed = 60974;

    assign hready = hreadyout;

    scr_slot_cap dut_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .downstreamPortStraps(straps),
        .eepromLoad, .powerLimitMsg, .hotplugCapable, .surpriseRemovalOk);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Sampled mid-cycle so the message edge has settled
    always @(negedge clk)
        if (powerLimitMsg.valid === 1'b1)
            msgQ.push_back(powerLimitMsg.limit);

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task conclude();
        $display("Checks %0d, mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task rst(input logic [2:0] s);
        rst_b <= 1'b0;
        straps <= s;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        mSlot = 13'h0000;
        mIl = 1'b0;
        mHp = s[0] | s[2];
        mSur = 1'b1;
        mLim = 10'h000;
        mUsed = 1'b0;
        msgQ.delete();
    endtask

    function automatic logic [31:0] expCap();
        return {mSlot, mIl, 1'b0, mLim, mHp, mSur, 5'h00};
    endfunction

    task readCap();
        logic [31:0] r;
        bus(1'b0, 32'(SCR_SLOT_CAP_ADDR), 32'h0000_0000, r);
        chk(r, expCap());
        chk({30'h0, hotplugCapable, surpriseRemovalOk}, {30'h0, mHp, mSur});
    endtask

    task capWr(input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, 32'(SCR_SLOT_CAP_ADDR), d, r);
        repeat (3) @(posedge clk);
        chk(32'(msgQ.size()), mUsed ? 32'h0 : 32'h1);
        if (!mUsed && msgQ.size() > 0)
            chk(32'(msgQ.pop_front()), 32'(d[16:7]));
        if (!mUsed)
            mLim = d[16:7];
        mUsed = 1'b1;
        msgQ.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d, r;
        {hsel, hwrite, htrans, haddr, hwdata, straps} = '0;
        eepromLoad = '0;
        rst_b = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rst(3'($random(seed)));
            readCap();
            bus(1'b1, 32'h0000_0100, 32'hFFFF_FFFF, r);
            bus(1'b0, 32'h0000_0100, 32'h0000_0000, r);
            chk(r, 32'h0000_0000);
            d = $random(seed);
            bus(1'b1, 32'(SCR_SLOT_INFO_ADDR), d, r);
            mSlot = d[12:0];
            d = $random(seed);
            bus(1'b1, 32'(SCR_GEN_CTRL_ADDR), d, r);
            {mIl, mHp, mSur} = d[15:13];
            readCap();
            if (i == 3)
            begin
                d = $random(seed);
                @(posedge clk);
                eepromLoad <= {1'b1, d[9:0]};
                @(posedge clk);
                eepromLoad <= '0;
                mLim = d[9:0];
                readCap();
            end
            d = $random(seed);
            d[16:15] = 2'(i);
            capWr(d);
            readCap();
            capWr($random(seed));
            readCap();
            $display("Test %0d finished", i);
        end
        conclude();
    end

    // Whole run needs under two hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        nErrors++;
        conclude();
    end
endmodule
